// >>> verilog/sync_ctl_pkg.sv
// Constants shared by the processor-control and barrier logic
package sync_ctl_pkg;
   localparam int unsigned FIELD_COUNT = 8;
   localparam int unsigned FIELD_WIDTH = 4;
   localparam int unsigned FLAGS_WIDTH = 32;
   localparam int unsigned SREG_NUM_WIDTH = 10;
   localparam int unsigned SREG_COUNT = 16;
   localparam int unsigned SREG_IDX_WIDTH = 4;
   // Primary and extended opcode fields
   localparam int unsigned OPCD_MSB = 31;
   localparam int unsigned OPCD_LSB = 26;
   localparam int unsigned XO_MSB = 10;
   localparam int unsigned XO_LSB = 1;
   localparam int unsigned MASK_MSB = 19;
   localparam int unsigned MASK_LSB = 12;
   localparam int unsigned REG_S_MSB = 25;
   localparam int unsigned REG_S_LSB = 21;
   localparam int unsigned SREG_LO_MSB = 20;
   localparam int unsigned SREG_LO_LSB = 16;
   localparam int unsigned SREG_HI_MSB = 15;
   localparam int unsigned SREG_HI_LSB = 11;
   localparam logic [5:0] OPCD_X = 6'h1F;
   localparam logic [5:0] OPCD_SYSCALL = 6'h11;
   localparam logic [5:0] OPCD_XL = 6'h13;
   localparam logic [9:0] XO_MTCRF = 10'h090;
   localparam logic [9:0] XO_MFSPR = 10'h153;
   localparam logic [9:0] XO_MTSPR = 10'h1D3;
   localparam logic [9:0] XO_IOBAR = 10'h356;
   localparam logic [9:0] XO_FSYNC = 10'h256;
   localparam logic [9:0] XO_MTMSR = 10'h092;
   localparam logic [9:0] XO_CBAR = 10'h096;
   localparam logic [9:0] XO_RFI = 10'h032;
   localparam logic [9:0] XO_RFCI = 10'h033;
   localparam logic [FLAGS_WIDTH-1:0] FLAGS_RESET = 32'h0000_0000;
   localparam logic [31:0] SREG_RESET = 32'h0000_0000;
endpackage : sync_ctl_pkg

// >>> verilog/sync_class_if.sv
// Decoded synchronization class of the instruction in decode
interface sync_class_if;
   logic ctx_sync;
   logic exe_sync;
   logic sto_sync;
   logic is_cbar;
   modport dec (output ctx_sync, output exe_sync, output sto_sync, output is_cbar);
   modport use_side (input ctx_sync, input exe_sync, input sto_sync, input is_cbar);
endinterface : sync_class_if

// >>> verilog/sync_classifier.sv
// Classifies an instruction word into its synchronization kinds
module sync_classifier (
   input wire logic [31:0] instr_i,
   sync_class_if.dec cls
);
   logic [5:0] opcd;
   logic [9:0] xo;
   logic is_x;
   logic is_xl;
   logic is_syscall;
   assign opcd = instr_i[sync_ctl_pkg::OPCD_MSB:sync_ctl_pkg::OPCD_LSB];
   assign xo = instr_i[sync_ctl_pkg::XO_MSB:sync_ctl_pkg::XO_LSB];
   assign is_x = (opcd == sync_ctl_pkg::OPCD_X);
   assign is_xl = (opcd == sync_ctl_pkg::OPCD_XL);
   assign is_syscall = (opcd == sync_ctl_pkg::OPCD_SYSCALL);
   // Context class: barrier, both returns, system call
   assign cls.is_cbar = is_xl && (xo == sync_ctl_pkg::XO_CBAR);
   assign cls.ctx_sync = cls.is_cbar || is_syscall || (is_xl && (xo == sync_ctl_pkg::XO_RFI ||
      xo == sync_ctl_pkg::XO_RFCI));
   // I/O barrier counts as storage and execution sync, same as full sync
   assign cls.sto_sync = is_x && (xo == sync_ctl_pkg::XO_IOBAR || xo == sync_ctl_pkg::XO_FSYNC);
   assign cls.exe_sync = cls.sto_sync || cls.ctx_sync || (is_x && xo == sync_ctl_pkg::XO_MTMSR);
endmodule : sync_classifier

// >>> verilog/cr_spr_sync_ctl.sv
// Condition-register and special-register moves plus barrier sequencing
// How it works
// - The condition field mask is eight bits of the instruction, its top bit picking field 0 and its bottom field 7.
// - A field loads from the source register only where its mask bit is one, else it keeps its value.
// - The special register number is rebuilt by swapping the two five-bit halves of its opcode field.
// - Move-from-special writes the destination register with the whole selected special register.
// - Move-to-special writes the selected special register with the source register.
// - The I/O barrier lets no later storage access start until every earlier one has completed.
// - The context barrier waits for all earlier instructions and holds later ones until it completes.
// - The context barrier flushes prefetched instructions so later ones are fetched anew.
// - The context barrier does not wait for memory accesses to finish against other devices.
// - Full sync waits for earlier instructions and their memory accesses before completing and holds later ones.
// - The I/O barrier and full sync are handled by the same sequence, both execution synchronizing.
// - Full sync only drains local storage, as there is no multiprocessor coherency to wait for.
// - Context barrier, both returns and system call are context synchronizing; the I/O barrier and full sync storage.
// - Both barriers, machine-state move, both returns, system call and full sync drain earlier instructions.
module cr_spr_sync_ctl #(
   parameter int unsigned SREG_N = sync_ctl_pkg::SREG_COUNT
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic issue_valid_i,
   input wire logic [31:0] issue_instr_i,
   input wire logic [31:0] source_gpr_i,
   input wire logic older_busy_i,
   input wire logic storage_busy_i,
   output logic issue_ready_o,
   output logic stall_later_o,
   output logic flush_prefetch_o,
   output logic complete_o,
   output logic gpr_we_o,
   output logic [31:0] gpr_wdata_o,
   output logic [31:0] condition_flags_register_o,
   output logic [9:0] special_reg_number_o,
   output logic ctx_sync_o,
   output logic sto_sync_o
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DRAIN = 3'b010,
      ST_FLUSH = 3'b100
   } sync_state_t;

   sync_class_if cls ();
   sync_state_t state_r;
   sync_state_t state_nxt;
   logic [31:0] cond_flags_r;
   logic [31:0] special_register_r [SREG_N];
   logic [31:0] gpr_wdata_r;
   logic gpr_we_r;
   logic complete_r;
   logic cbar_pend_r;
   logic [5:0] opcd;
   logic [9:0] xo;
   logic [7:0] cond_field_mask;
   logic [9:0] special_reg_number;
   logic [31:0] cond_flags_nxt;
   logic take;
   logic is_mtcrf;
   logic is_mfspr;
   logic is_mtspr;
   logic drained;

   // Swapped halves recover the register number
   function automatic logic [9:0] sreg_decode(input logic [31:0] w);
      sreg_decode = {w[sync_ctl_pkg::SREG_HI_MSB:sync_ctl_pkg::SREG_HI_LSB],
                     w[sync_ctl_pkg::SREG_LO_MSB:sync_ctl_pkg::SREG_LO_LSB]};
   endfunction : sreg_decode

   // Widens the field mask to one bit per flag bit, kept apart from the merge it checks
   function automatic logic [31:0] field_bits(input logic [7:0] m);
      field_bits = 32'h0000_0000;
      for (int f = 0; f < 8; f++) begin
         field_bits[31 - 4 * f -: 4] = {4{m[7 - f]}};
      end
   endfunction : field_bits

   sync_classifier u_cls (
      .instr_i(issue_instr_i),
      .cls(cls)
   );

   assign opcd = issue_instr_i[sync_ctl_pkg::OPCD_MSB:sync_ctl_pkg::OPCD_LSB];
   assign xo = issue_instr_i[sync_ctl_pkg::XO_MSB:sync_ctl_pkg::XO_LSB];
   assign cond_field_mask = issue_instr_i[sync_ctl_pkg::MASK_MSB:sync_ctl_pkg::MASK_LSB];
   assign special_reg_number = sreg_decode(issue_instr_i);
   assign is_mtcrf = (opcd == sync_ctl_pkg::OPCD_X) && (xo == sync_ctl_pkg::XO_MTCRF);
   assign is_mfspr = (opcd == sync_ctl_pkg::OPCD_X) && (xo == sync_ctl_pkg::XO_MFSPR);
   assign is_mtspr = (opcd == sync_ctl_pkg::OPCD_X) && (xo == sync_ctl_pkg::XO_MTSPR);
   assign take = issue_valid_i && issue_ready_o;
   // Context barrier skips the storage drain; other devices are not waited on
   assign drained = !older_busy_i && (cbar_pend_r || !storage_busy_i);

   // Masked field merge, mask bit 7-i picks field i
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_field
         localparam int unsigned HI = 31 - 4 * gi;
         assign cond_flags_nxt[HI -: 4] = cond_field_mask[7 - gi] ? source_gpr_i[HI -: 4] : cond_flags_r[HI -: 4];
      end
   endgenerate

   // Barrier sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (issue_valid_i && cls.exe_sync) begin
               state_nxt = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (drained) begin
               state_nxt = cbar_pend_r ? ST_FLUSH : ST_IDLE;
            end
         end
         ST_FLUSH: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Remember whether the barrier is the context kind
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cbar_pend_r <= 1'b0;
      end else if (state_r == ST_IDLE && issue_valid_i) begin
         cbar_pend_r <= cls.is_cbar;
      end
   end

   // Sync instructions issue only once drained; later ones stall until then
   assign issue_ready_o = (state_r == ST_IDLE) ? !cls.exe_sync :
                          ((state_r == ST_DRAIN) && drained && !cbar_pend_r) || (state_r == ST_FLUSH);
   assign stall_later_o = (state_r != ST_IDLE);
   assign flush_prefetch_o = (state_r == ST_FLUSH);
   assign ctx_sync_o = cls.ctx_sync;
   assign sto_sync_o = cls.sto_sync;

   // Condition register update
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cond_flags_r <= sync_ctl_pkg::FLAGS_RESET;
      end else if (take && is_mtcrf) begin
         cond_flags_r <= cond_flags_nxt;
      end
   end

   // Special register file; numbers beyond the array are dropped on write
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < SREG_N; i++) begin
            special_register_r[i] <= sync_ctl_pkg::SREG_RESET;
         end
      end else if (take && is_mtspr && special_reg_number < 10'(SREG_N)) begin
         special_register_r[special_reg_number[sync_ctl_pkg::SREG_IDX_WIDTH-1:0]] <= source_gpr_i;
      end
   end

   // Register result and completion
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         gpr_we_r <= 1'b0;
         gpr_wdata_r <= 32'h0000_0000;
         complete_r <= 1'b0;
      end else begin
         gpr_we_r <= take && is_mfspr;
         complete_r <= take;
         if (take && is_mfspr) begin
            gpr_wdata_r <= (special_reg_number < 10'(SREG_N)) ?
               special_register_r[special_reg_number[sync_ctl_pkg::SREG_IDX_WIDTH-1:0]] : 32'h0000_0000;
         end
      end
   end

   assign gpr_we_o = gpr_we_r;
   assign gpr_wdata_o = gpr_wdata_r;
   assign complete_o = complete_r;
   assign condition_flags_register_o = cond_flags_r;
   assign special_reg_number_o = special_reg_number;

   AST_HOLD_WHILE_BUSY: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_DRAIN && older_busy_i) |-> !issue_ready_o)
      else $error("issue accepted while older work busy");
   AST_STORE_DRAIN: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_DRAIN && !cbar_pend_r && storage_busy_i) |-> stall_later_o && !issue_ready_o)
      else $error("storage barrier released early");
   AST_FLUSH_AFTER_CBAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_DRAIN && cbar_pend_r && drained) |=> flush_prefetch_o ##1 !flush_prefetch_o)
      else $error("no prefetch flush after context barrier");
   AST_CBAR_NO_STORE_WAIT: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_DRAIN && cbar_pend_r && !older_busy_i) |=> flush_prefetch_o)
      else $error("context barrier waited on storage");
   AST_MTCRF_MERGE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_mtcrf) |=> cond_flags_r == (($past(source_gpr_i) & field_bits($past(cond_field_mask))) |
         ($past(cond_flags_r) & ~field_bits($past(cond_field_mask)))))
      else $error("condition merge wrong");
   AST_FLAGS_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !(take && is_mtcrf) |=> $stable(cond_flags_r))
      else $error("condition register changed without move");
   AST_MFSPR_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_mfspr) |=> gpr_we_o)
      else $error("move-from-special gave no write");
   AST_SREG_ROUNDTRIP: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_mtspr && special_reg_number == 10'h005) |=> special_register_r[5] == $past(source_gpr_i))
      else $error("special register write lost");
   AST_FLUSH_ONLY_CBAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
      flush_prefetch_o |-> cbar_pend_r && issue_ready_o)
      else $error("prefetch flush without context barrier");
   AST_EXE_STALL: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && issue_valid_i && cls.exe_sync) |-> !issue_ready_o ##1 stall_later_o)
      else $error("sync instruction issued without drain");
   AST_IOBAR_SAME: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cls.sto_sync && issue_valid_i && state_r == ST_IDLE) |-> cls.exe_sync ##1 !cbar_pend_r)
      else $error("storage barriers not treated alike");

   COV_MTCRF: cover property (@(posedge core_clk_i) take && is_mtcrf && cond_field_mask == 8'h64);
   COV_CBAR: cover property (@(posedge core_clk_i) flush_prefetch_o);
   COV_SYNC_WAIT: cover property (@(posedge core_clk_i) state_r == ST_DRAIN && storage_busy_i ##1 issue_ready_o);
   COV_MFSPR: cover property (@(posedge core_clk_i) gpr_we_o);
endmodule : cr_spr_sync_ctl

// >>> verif/tb_top.sv
// Self-checking bench for the condition and special register moves and barriers
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic issue_valid_i = 1'b0;
   logic [31:0] issue_instr_i = 32'h0000_0000;
   logic [31:0] source_gpr_i = 32'h0000_0000;
   logic older_busy_i = 1'b0;
   logic storage_busy_i = 1'b0;
   logic issue_ready_o, stall_later_o, flush_prefetch_o, complete_o, gpr_we_o, ctx_sync_o, sto_sync_o;
   logic [31:0] gpr_wdata_o, condition_flags_register_o;
   logic [9:0] special_reg_number_o;
   logic seen_flush;
   int fail_count = 0;
   int comparisons = 0;
   cr_spr_sync_ctl #(.SREG_N(16)) i_cr_spr_sync_ctl (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .issue_valid_i(issue_valid_i), .issue_instr_i(issue_instr_i), .source_gpr_i(source_gpr_i),
      .older_busy_i(older_busy_i), .storage_busy_i(storage_busy_i), .issue_ready_o(issue_ready_o),
      .stall_later_o(stall_later_o), .flush_prefetch_o(flush_prefetch_o), .complete_o(complete_o),
      .gpr_we_o(gpr_we_o), .gpr_wdata_o(gpr_wdata_o), .condition_flags_register_o(condition_flags_register_o),
      .special_reg_number_o(special_reg_number_o), .ctx_sync_o(ctx_sync_o), .sto_sync_o(sto_sync_o));
   // 50 MHz core clock
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic chk1(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask : chk1
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk32
   function automatic logic [31:0] xf(input logic [5:0] op, input logic [9:0] xo);
      return {op, 15'h0000, xo, 1'b0};
   endfunction : xf
   // Register number lands in two swapped five-bit halves
   function automatic logic [31:0] sreg_ins(input logic [9:0] xo, input logic [9:0] n);
      return xf(sync_ctl_pkg::OPCD_X, xo) | {11'h000, n[4:0], n[9:5], 11'h000};
   endfunction : sreg_ins
   function automatic logic [31:0] crf(input logic [7:0] m);
      return xf(sync_ctl_pkg::OPCD_X, sync_ctl_pkg::XO_MTCRF) | {12'h000, m, 12'h000};
   endfunction : crf
   // Entered just after a falling edge; bounded wait for acceptance, then one edge for completion
   task automatic issue(input logic [31:0] ins, input logic [31:0] src);
      int n;
      n = 0;
      issue_instr_i = ins;
      source_gpr_i = src;
      issue_valid_i = 1'b1;
      #1;
      while (issue_ready_o !== 1'b1 && n < 40) begin
         @(negedge core_clk_i);
         #1;
         n++;
      end
      if (issue_ready_o !== 1'b1) begin
         fail_count++;
         $display("unexpected acceptance wait: expected ready seen none");
         finish_test();
      end
      seen_flush = flush_prefetch_o;
      @(negedge core_clk_i);
      issue_valid_i = 1'b0;
      #1;
      chk1("complete", 1'b1, complete_o);
   endtask : issue
   // Synchronous reset held ten cycles
   task automatic do_reset();
      @(negedge core_clk_i);
      rst_i = 1'b1;
      repeat (10) @(negedge core_clk_i);
      rst_i = 1'b0;
      #1;
   endtask : do_reset
   // Cumulative field-mask rows: mask, source, expected flags after the move
   logic [7:0] rmask [5] = '{8'hFF, 8'h64, 8'h00, 8'h01, 8'h80};
   logic [31:0] rsrc [5] = '{32'h1234_5678, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'hA000_0000};
   logic [31:0] rexp [5] = '{32'h1234_5678, 32'h1FF4_5F78, 32'h1FF4_5F78, 32'h1FF4_5F70, 32'hAFF4_5F70};
   // Draining kinds: I/O barrier, full sync, state move, context barrier, two returns, system call
   logic [31:0] dins [7];
   logic [0:6] ctx_e = 7'b0001111;
   logic [0:6] sto_e = 7'b1100000;
   initial begin
      repeat (5000) @(posedge core_clk_i);
      fail_count++;
      $display("unexpected run length: expected end seen hang");
      finish_test();
   end
   initial begin
      dins = '{xf(6'h1F, sync_ctl_pkg::XO_IOBAR), xf(6'h1F, sync_ctl_pkg::XO_FSYNC), xf(6'h1F, sync_ctl_pkg::XO_MTMSR),
         xf(6'h13, sync_ctl_pkg::XO_CBAR), xf(6'h13, sync_ctl_pkg::XO_RFI), xf(6'h13, sync_ctl_pkg::XO_RFCI),
         xf(sync_ctl_pkg::OPCD_SYSCALL, 10'h001)};
      do_reset();
      chk32("flags after reset", 32'h0000_0000, condition_flags_register_o);
      chk1("stall after reset", 1'b0, stall_later_o);
      for (int i = 0; i < 5; i++) begin
         issue(crf(rmask[i]), rsrc[i]);
         chk32("flags", rexp[i], condition_flags_register_o);
      end
      // Split register number, then write, dropped write, reads
      issue_instr_i = sreg_ins(sync_ctl_pkg::XO_MFSPR, 10'h128);
      #1;
      chk32("register number", 32'h0000_0128, {22'h000000, special_reg_number_o});
      issue(sreg_ins(sync_ctl_pkg::XO_MTSPR, 10'h005), 32'hCAFE_1234);
      chk1("no gpr write on move-to", 1'b0, gpr_we_o);
      issue(sreg_ins(sync_ctl_pkg::XO_MTSPR, 10'h015), 32'hFFFF_FFFF);
      issue(sreg_ins(sync_ctl_pkg::XO_MFSPR, 10'h005), 32'h0000_0000);
      chk1("gpr write", 1'b1, gpr_we_o);
      chk32("special read", 32'hCAFE_1234, gpr_wdata_o);
      issue(sreg_ins(sync_ctl_pkg::XO_MFSPR, 10'h128), 32'h0000_0000);
      chk32("unmapped read", 32'h0000_0000, gpr_wdata_o);
      // Every draining kind is held back while older work is in flight
      for (int i = 0; i < 7; i++) begin
         older_busy_i = 1'b1;
         storage_busy_i = (i == 3); // Context barrier must not wait on storage
         issue_instr_i = dins[i];
         issue_valid_i = 1'b1;
         #1;
         chk1("ctx class", ctx_e[i], ctx_sync_o);
         chk1("sto class", sto_e[i], sto_sync_o);
         chk1("ready while older busy", 1'b0, issue_ready_o);
         @(negedge core_clk_i);
         chk1("stall later", 1'b1, stall_later_o);
         chk1("ready in drain", 1'b0, issue_ready_o);
         older_busy_i = 1'b0;
         issue(dins[i], 32'h0000_0000);
         chk1("prefetch flush", i == 3, seen_flush);
         chk1("flush pulse ends", 1'b0, flush_prefetch_o);
         storage_busy_i = 1'b0;
      end
      // Both storage barriers wait for outstanding storage accesses
      for (int j = 0; j < 2; j++) begin
         older_busy_i = 1'b1;
         storage_busy_i = 1'b1;
         issue_instr_i = dins[j];
         issue_valid_i = 1'b1;
         @(negedge core_clk_i);
         older_busy_i = 1'b0;
         @(negedge core_clk_i);
         #1;
         chk1("ready while storage busy", 1'b0, issue_ready_o);
         chk1("stall while storage busy", 1'b1, stall_later_o);
         storage_busy_i = 1'b0;
         issue(dins[j], 32'h0000_0000);
      end
      // One idle cycle later the completion pulse and the stall are both gone
      @(negedge core_clk_i);
      #1;
      chk1("complete pulse ends", 1'b0, complete_o);
      chk1("stall released", 1'b0, stall_later_o);
      // Reset in mid-run clears flags and special registers
      do_reset();
      chk32("flags after second reset", 32'h0000_0000, condition_flags_register_o);
      issue(sreg_ins(sync_ctl_pkg::XO_MFSPR, 10'h005), 32'h0000_0000);
      chk32("special after reset", 32'h0000_0000, gpr_wdata_o);
      finish_test();
   end
endmodule : tb_top
